/* rtl/tcc_cfg.svh */
`ifndef TCC_CFG_SVH
`define TCC_CFG_SVH
// ****************************************
// Register byte addresses
// ****************************************
`define TCC_ADR_CNT_LO 8'h00
`define TCC_ADR_CNT_HI 8'h04
`define TCC_ADR_CAP_LO 8'h08
`define TCC_ADR_CAP_HI 8'h0c
`define TCC_ADR_CTRL_A 8'h10
`define TCC_ADR_CTRL_B 8'h14
`define TCC_ADR_FLAGS 8'h18
`define TCC_ADR_IRQ_EN 8'h1c
`define TCC_ADR_CMP_CS 8'h20
// ****************************************
// Field positions
// ****************************************
`define TCC_A_WGM_LO 0
`define TCC_B_CS 0
`define TCC_B_WGM_HI 3
`define TCC_B_EDGE 6
`define TCC_B_FILT 7
`define TCC_F_OVF 0
`define TCC_F_CAP 1
`define TCC_CMP_SEL 2
// ****************************************
// Values
// ****************************************
`define TCC_MAX 16'hffff
`define TCC_BOTTOM 16'h0000
`define TCC_TOP_8B 16'h00ff
`define TCC_TOP_9B 16'h01ff
`define TCC_TOP_10B 16'h03ff
`define TCC_RST_BYTE 8'h00
`define TCC_RST_WORD 16'h0000
`define TCC_RST_BUS 32'h0000_0000
`endif

/* rtl/tcc_pkg.sv */
// ****************************************
// Types of the timer/counter core
// ****************************************
package tcc_pkg;
  // Waveform mode numbers, split over control A and B
  typedef enum logic [3:0] {
    wgm_normal = 4'h0, wgm_pc8 = 4'h1, wgm_pc9 = 4'h2, wgm_pc10 = 4'h3,
    wgm_ctc_ocr = 4'h4, wgm_fast8 = 4'h5, wgm_fast9 = 4'h6, wgm_fast10 = 4'h7,
    wgm_pfc_icr = 4'h8, wgm_pfc_ocr = 4'h9, wgm_pc_icr = 4'ha, wgm_pc_ocr = 4'hb,
    wgm_ctc_icr = 4'hc, wgm_rsvd = 4'hd, wgm_fast_icr = 4'he, wgm_fast_ocr = 4'hf
  } tcc_wgm_t;
  // Tick source select values
  typedef enum logic [2:0] {
    src_none = 3'h0, src_sys = 3'h1, src_pre_a = 3'h2, src_pre_b = 3'h3,
    src_pre_c = 3'h4, src_pre_d = 3'h5, src_ext_fall = 3'h6, src_ext_rise = 3'h7
  } tcc_src_t;
endpackage : tcc_pkg

/* rtl/tcc_core.sv */
// The register offsets and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "tcc_cfg.svh"

// Notes on behaviour
// RULE_01 - Counter high-byte location always reaches the shared holding byte
// RULE_02 - Low read snapshots high byte; low write loads holding byte plus data
// RULE_03 - A low-byte write leaves the holding byte untouched
// RULE_04 - Software masks interrupts across every two-byte access
// RULE_05 - Three-bit tick source field; zero stops the counter
// RULE_06 - Each tick clears, increments or decrements per mode
// RULE_07 - Counter is readable and writable whether ticking or not
// RULE_08 - Software counter write beats a same-cycle count or clear
// RULE_09 - Four-bit waveform mode split across control A and B
// RULE_10 - Overflow flag set as the mode defines, can request interrupt
// RULE_11 - Capture fires on a source level change matching edge select
// RULE_12 - Capture copies the whole counter into capture value
// RULE_13 - Capture flag set in the same cycle as the copy
// RULE_14 - Capture flag with enable set raises capture interrupt
// RULE_15 - Capture flag clears on service or on writing one
// RULE_16 - Capture low read snapshots high byte; high read returns holding
// RULE_17 - Capture value writable only in modes using it as TOP
// RULE_18 - Software writes capture high byte first, then low
// RULE_19 - Comparator select routes comparator output to capture unit
// RULE_20 - Software clears capture flag after switching source
// RULE_21 - Capture inputs synchronised; filter adds four cycles delay
// RULE_22 - Capture path disabled only while capture value is TOP
// RULE_23 - Capture follows the pin level whatever drives it
// RULE_24 - One holding byte serves all wide registers
// RULE_25 - Bottom indication at zero count; maximum count is all ones
// RULE_26 - Filter output changes after four equal system-clock samples
module tcc_core #(
  parameter int CNT_W = 16, // Counter width
  parameter int FILT_LEN = 4 // Filter sample count
) (
  input wire logic clk_in, // System clock
  input wire logic reset_n_in, // Synchronous reset
  input wire logic wb_cyc_in, // Bus cycle
  input wire logic wb_stb_in, // Bus strobe
  input wire logic wb_we_in, // Write enable
  input wire logic [7:0] wb_adr_in, // Byte address
  input wire logic [3:0] wb_sel_in, // Byte lanes
  input wire logic [31:0] wb_dat_in, // Write data
  output logic [31:0] wb_dat_out, // Read data
  output logic wb_ack_out, // Bus acknowledge
  input wire logic [3:0] prescale_tick_in, // Prescaler taps
  input wire logic external_tick_pin_in, // External tick pin
  input wire logic capture_pin_in, // Capture pin level
  input wire logic comparator_output_in, // Comparator output
  input wire logic capture_irq_ack_in, // Capture serviced
  input wire logic overflow_irq_ack_in, // Overflow serviced
  output logic capture_irq_out, // Capture request
  output logic overflow_irq_out, // Overflow request
  output logic bottom_out // Counter at zero
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (CNT_W != 16) begin : g_bad_width
    $error("Counter width must be 16");
  end
  if (FILT_LEN < 2) begin : g_bad_filt
    $error("Filter needs at least two samples");
  end

  // ****************************************
  // Declarations
  // ****************************************
  logic [CNT_W-1:0] count_r, count_nxt, cap_r, top;
  logic [7:0] temp_r, ctrl_a_r, ctrl_b_r, cmp_cs_r, rdata;
  logic [1:0] flags_r, flags_nxt, irq_en_r, irq_en_nxt, flag_set, flag_clr;
  logic dir_down_r, dir_nxt, ovf_evt, tick, req, wr, rd;
  logic wr_cnt_lo, wr_cap_lo, wr_hi, rd_cnt_lo, rd_cap_lo;
  logic dual, fast, ctc, icr_top, cap_trig;
  logic [2:0] meta_r, sync_r;
  logic ext_prev_r, src_lvl, edge_in, edge_prev_r, filt_out_r;
  logic [FILT_LEN-2:0] filt_sh_r;
  logic [FILT_LEN-1:0] filt_win;
  tcc_pkg::tcc_wgm_t wgm;
  tcc_pkg::tcc_src_t src;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001; // Step of one count

  // ****************************************
  // Bus decode
  // ****************************************
  // One request per cycle; ack gap keeps a held strobe from repeating
  assign req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  assign wr = req & wb_we_in & wb_sel_in[0];
  assign rd = req & ~wb_we_in;
  assign wr_cnt_lo = wr && (wb_adr_in == `TCC_ADR_CNT_LO);
  assign wr_cap_lo = wr && (wb_adr_in == `TCC_ADR_CAP_LO) && icr_top; // [RULE_17]
  assign wr_hi = wr && (wb_adr_in == `TCC_ADR_CNT_HI || wb_adr_in == `TCC_ADR_CAP_HI);
  assign rd_cnt_lo = rd && (wb_adr_in == `TCC_ADR_CNT_LO);
  assign rd_cap_lo = rd && (wb_adr_in == `TCC_ADR_CAP_LO);

  // Mode field lives in two registers
  assign wgm = tcc_pkg::tcc_wgm_t'({ctrl_b_r[`TCC_B_WGM_HI +: 2],
                                    ctrl_a_r[`TCC_A_WGM_LO +: 2]}); // [RULE_09]
  assign src = tcc_pkg::tcc_src_t'(ctrl_b_r[`TCC_B_CS +: 3]);

  // Mode classes
  assign icr_top = wgm inside {tcc_pkg::wgm_pfc_icr, tcc_pkg::wgm_pc_icr,
                               tcc_pkg::wgm_ctc_icr, tcc_pkg::wgm_fast_icr};
  assign dual = wgm inside {tcc_pkg::wgm_pc8, tcc_pkg::wgm_pc9, tcc_pkg::wgm_pc10,
                            tcc_pkg::wgm_pfc_icr, tcc_pkg::wgm_pfc_ocr,
                            tcc_pkg::wgm_pc_icr, tcc_pkg::wgm_pc_ocr};
  assign fast = wgm inside {tcc_pkg::wgm_fast8, tcc_pkg::wgm_fast9, tcc_pkg::wgm_fast10,
                            tcc_pkg::wgm_fast_icr, tcc_pkg::wgm_fast_ocr};
  assign ctc = wgm inside {tcc_pkg::wgm_ctc_ocr, tcc_pkg::wgm_ctc_icr};

  // TOP per mode; compare-register modes fall back to MAX (no compare unit here)
  always_comb begin
    case (wgm)
      tcc_pkg::wgm_pc8, tcc_pkg::wgm_fast8: top = `TCC_TOP_8B;
      tcc_pkg::wgm_pc9, tcc_pkg::wgm_fast9: top = `TCC_TOP_9B;
      tcc_pkg::wgm_pc10, tcc_pkg::wgm_fast10: top = `TCC_TOP_10B;
      tcc_pkg::wgm_pfc_icr, tcc_pkg::wgm_pc_icr,
      tcc_pkg::wgm_ctc_icr, tcc_pkg::wgm_fast_icr: top = cap_r;
      default: top = `TCC_MAX;
    endcase
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Two flops per pin; only sync_r is looked at by logic
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      meta_r <= 3'h0;
      sync_r <= 3'h0;
    end else begin
      meta_r <= {comparator_output_in, capture_pin_in, external_tick_pin_in}; // [RULE_23]
      sync_r <= meta_r; // [RULE_21]
    end
  end

  // ****************************************
  // Tick selection
  // ****************************************
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      ext_prev_r <= 1'b0;
    end else begin
      ext_prev_r <= sync_r[0];
    end
  end

  // Zero selects nothing, so the counter stands still
  always_comb begin
    case (src)
      tcc_pkg::src_none: tick = 1'b0; // [RULE_05]
      tcc_pkg::src_sys: tick = 1'b1;
      tcc_pkg::src_pre_a: tick = prescale_tick_in[0];
      tcc_pkg::src_pre_b: tick = prescale_tick_in[1];
      tcc_pkg::src_pre_c: tick = prescale_tick_in[2];
      tcc_pkg::src_pre_d: tick = prescale_tick_in[3];
      tcc_pkg::src_ext_fall: tick = ext_prev_r & ~sync_r[0];
      tcc_pkg::src_ext_rise: tick = ~ext_prev_r & sync_r[0];
      default: tick = 1'b0;
    endcase
  end

  // ****************************************
  // Counter unit
  // ****************************************
  // Next count per mode; software write wins and drops the tick's count and overflow, but not a dual-slope turn
  always_comb begin
    count_nxt = count_r;
    dir_nxt = dir_down_r;
    ovf_evt = 1'b0;
    if (tick) begin // [RULE_06]
      if (dual) begin
        if (!dir_down_r) begin
          if (count_r >= top) begin
            dir_nxt = 1'b1;
            count_nxt = count_r - CNT_ONE;
          end else begin
            count_nxt = count_r + CNT_ONE;
          end
        end else if (count_r == `TCC_BOTTOM) begin
          dir_nxt = 1'b0;
          count_nxt = count_r + CNT_ONE;
          ovf_evt = 1'b1; // [RULE_10]
        end else begin
          count_nxt = count_r - CNT_ONE;
        end
      end else if ((fast || ctc) && count_r == top) begin
        count_nxt = `TCC_BOTTOM;
        ovf_evt = fast; // [RULE_10]
      end else begin
        count_nxt = count_r + CNT_ONE;
        ovf_evt = (count_r == `TCC_MAX); // [RULE_10] [RULE_25]
      end
    end
    if (wr_cnt_lo) begin
      count_nxt = {temp_r, wb_dat_in[7:0]}; // [RULE_02] [RULE_07] [RULE_08]
      ovf_evt = 1'b0; // [RULE_08]
    end
    if (!dual) begin
      dir_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      count_r <= `TCC_RST_WORD;
      dir_down_r <= 1'b0;
      bottom_out <= 1'b1;
    end else begin
      count_r <= count_nxt;
      dir_down_r <= dir_nxt;
      bottom_out <= (count_nxt == `TCC_BOTTOM); // [RULE_25]
    end
  end

  // ****************************************
  // Capture input path
  // ****************************************
  // Source switch can itself look like an edge; software clears the flag
  assign src_lvl = cmp_cs_r[`TCC_CMP_SEL] ? sync_r[2] : sync_r[1]; // [RULE_19]
  assign filt_win = {filt_sh_r, src_lvl};

  // Filter shifts always, so enabling it mid-run starts from real history
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      filt_sh_r <= '0;
      filt_out_r <= 1'b0;
    end else begin
      filt_sh_r <= filt_win[FILT_LEN-2:0];
      if (&filt_win) begin
        filt_out_r <= 1'b1; // [RULE_26]
      end else if (~|filt_win) begin
        filt_out_r <= 1'b0; // [RULE_26]
      end
    end
  end

  assign edge_in = ctrl_b_r[`TCC_B_FILT] ? filt_out_r : src_lvl; // [RULE_21]

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      edge_prev_r <= 1'b0;
    end else begin
      edge_prev_r <= edge_in;
    end
  end

  // Edge select bit: one picks rising, zero falling
  assign cap_trig = !icr_top && (ctrl_b_r[`TCC_B_EDGE] ? (edge_in & ~edge_prev_r)
                                 : (~edge_in & edge_prev_r)); // [RULE_11] [RULE_22]

  // Capture overwrites; unread old value is lost by design
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      cap_r <= `TCC_RST_WORD;
    end else if (cap_trig) begin
      cap_r <= count_r; // [RULE_12]
    end else if (wr_cap_lo) begin
      cap_r <= {temp_r, wb_dat_in[7:0]}; // [RULE_17]
    end
  end

  // ****************************************
  // Shared holding byte
  // ****************************************
  // Single byte for every wide register; low-byte writes never change it [RULE_03]
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      temp_r <= `TCC_RST_BYTE;
    end else if (wr_hi) begin
      temp_r <= wb_dat_in[7:0]; // [RULE_01] [RULE_24]
    end else if (rd_cnt_lo) begin
      temp_r <= count_r[15:8]; // [RULE_02]
    end else if (rd_cap_lo) begin
      temp_r <= cap_r[15:8]; // [RULE_16]
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      ctrl_a_r <= `TCC_RST_BYTE;
      ctrl_b_r <= `TCC_RST_BYTE;
      cmp_cs_r <= `TCC_RST_BYTE;
    end else begin
      if (wr && wb_adr_in == `TCC_ADR_CTRL_A) begin
        ctrl_a_r <= wb_dat_in[7:0];
      end
      if (wr && wb_adr_in == `TCC_ADR_CTRL_B) begin
        ctrl_b_r <= wb_dat_in[7:0];
      end
      if (wr && wb_adr_in == `TCC_ADR_CMP_CS) begin
        cmp_cs_r <= wb_dat_in[7:0];
      end
    end
  end

  // ****************************************
  // Flags and requests
  // ****************************************
  // Set beats clear, so an event in the clear cycle survives
  always_comb begin
    flag_set = 2'h0;
    flag_set[`TCC_F_OVF] = ovf_evt;
    flag_set[`TCC_F_CAP] = cap_trig; // [RULE_13]
    flag_clr = 2'h0;
    if (wr && wb_adr_in == `TCC_ADR_FLAGS) begin
      flag_clr = wb_dat_in[1:0]; // [RULE_15]
    end
    flag_clr[`TCC_F_OVF] = flag_clr[`TCC_F_OVF] | overflow_irq_ack_in;
    flag_clr[`TCC_F_CAP] = flag_clr[`TCC_F_CAP] | capture_irq_ack_in; // [RULE_15]
    flags_nxt = (flags_r & ~flag_clr) | flag_set;
    irq_en_nxt = irq_en_r;
    if (wr && wb_adr_in == `TCC_ADR_IRQ_EN) begin
      irq_en_nxt = wb_dat_in[1:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      flags_r <= 2'h0;
      irq_en_r <= 2'h0;
      capture_irq_out <= 1'b0;
      overflow_irq_out <= 1'b0;
    end else begin
      flags_r <= flags_nxt;
      irq_en_r <= irq_en_nxt;
      capture_irq_out <= flags_nxt[`TCC_F_CAP] & irq_en_nxt[`TCC_F_CAP]; // [RULE_14]
      overflow_irq_out <= flags_nxt[`TCC_F_OVF] & irq_en_nxt[`TCC_F_OVF]; // [RULE_10]
    end
  end

  // ****************************************
  // Bus answer
  // ****************************************
  // High locations answer from the holding byte only
  always_comb begin
    case (wb_adr_in)
      `TCC_ADR_CNT_LO: rdata = count_r[7:0];
      `TCC_ADR_CNT_HI: rdata = temp_r; // [RULE_01]
      `TCC_ADR_CAP_LO: rdata = cap_r[7:0];
      `TCC_ADR_CAP_HI: rdata = temp_r; // [RULE_16]
      `TCC_ADR_CTRL_A: rdata = ctrl_a_r;
      `TCC_ADR_CTRL_B: rdata = ctrl_b_r;
      `TCC_ADR_FLAGS: rdata = {6'h00, flags_r};
      `TCC_ADR_IRQ_EN: rdata = {6'h00, irq_en_r};
      `TCC_ADR_CMP_CS: rdata = cmp_cs_r;
      default: rdata = 8'h00;
    endcase
  end

  // Every address acks one cycle later; unmapped reads give zero
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= `TCC_RST_BUS;
    end else begin
      wb_ack_out <= req;
      if (rd) begin
        wb_dat_out <= {24'h000000, rdata};
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  a_low_read_snap: assert property ( // [RULE_02]
    rd_cnt_lo |=> temp_r == $past(count_r[15:8]))
    else $error("Counter low read did not snapshot high byte");

  a_low_write_load: assert property ( // [RULE_08]
    wr_cnt_lo |=> count_r == {$past(temp_r), $past(wb_dat_in[7:0])})
    else $error("Counter low write not loaded over tick");

  a_temp_kept: assert property ( // [RULE_03]
    (wr_cnt_lo || wr_cap_lo) |=> $stable(temp_r))
    else $error("Holding byte changed on low write");

  a_stop_hold: assert property ( // [RULE_05]
    (src == tcc_pkg::src_none && !wr_cnt_lo) |=> $stable(count_r))
    else $error("Counter moved with no tick source");

  a_cap_copy: assert property ( // [RULE_12]
    cap_trig |=> cap_r == $past(count_r) && flags_r[`TCC_F_CAP])
    else $error("Capture copy or flag missing");

  a_cap_blocked: assert property ( // [RULE_22]
    (icr_top && !wr_cap_lo) |=> $stable(cap_r))
    else $error("Capture value moved while it is TOP");

  a_high_read: assert property ( // [RULE_16]
    (rd && wb_adr_in == `TCC_ADR_CAP_HI) |=> wb_ack_out && wb_dat_out[7:0] == $past(temp_r))
    else $error("High read did not return holding byte");

  a_irq_follow: assert property ( // [RULE_14]
    capture_irq_out == (flags_r[`TCC_F_CAP] && irq_en_r[`TCC_F_CAP]))
    else $error("Capture request does not follow flag and enable");

  a_flag_clear: assert property ( // [RULE_15]
    (capture_irq_ack_in && !cap_trig) |=> !flags_r[`TCC_F_CAP])
    else $error("Capture flag not cleared on service");

  a_filt_delay: assert property ( // [RULE_26]
    (ctrl_b_r[`TCC_B_FILT] && $changed(src_lvl)) |=> filt_out_r != src_lvl || $stable(filt_out_r))
    else $error("Filter passed a single-sample change");

endmodule : tcc_core
`default_nettype wire

/* tb/tcc_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Byte-wide CPU bus master model
// ****************************************
module tcc_cpu_model (
  input wire logic clk_in, // System clock
  input wire logic ack_in, // Slave acknowledge
  input wire logic [31:0] dat_in, // Read data
  output logic cyc_out, // Bus cycle
  output logic stb_out, // Bus strobe
  output logic we_out, // Write enable
  output logic [7:0] adr_out, // Byte address
  output logic [3:0] sel_out, // Byte lanes
  output logic [31:0] dat_out // Write data
);
  // Idle bus from time zero
  initial begin
    cyc_out = 1'b0;
    stb_out = 1'b0;
    we_out = 1'b0;
    adr_out = 8'h00;
    sel_out = 4'h0;
    dat_out = 32'h0000_0000;
  end

  // One classic cycle; held until ack is sampled, bounded wait
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    int n;
    @(posedge clk_in);
    cyc_out <= 1'b1;
    stb_out <= 1'b1;
    we_out <= w;
    adr_out <= a;
    sel_out <= 4'h1;
    dat_out <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (ack_in !== 1'b1 && n < 50);
    q = dat_in[7:0];
    cyc_out <= 1'b0;
    stb_out <= 1'b0;
    we_out <= 1'b0;
    if (n >= 50) begin
      $display("ERROR bus ack expected 1 seen none");
      tb.n_errors++;
      tb.print_verdict();
    end
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    xfer(1'b0, a, 8'h00, q);
  endtask : rd

  // High byte first, low commits; pair is never split
  task automatic wr16(input logic [7:0] hi, input logic [7:0] lo, input logic [15:0] v);
    wr(hi, v[15:8]);
    wr(lo, v[7:0]);
  endtask : wr16

  // Low first so the high byte is snapshotted
  task automatic rd16(input logic [7:0] lo, input logic [7:0] hi, output logic [15:0] v);
    rd(lo, v[7:0]);
    rd(hi, v[15:8]);
  endtask : rd16
endmodule : tcc_cpu_model
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tcc_cfg.svh"
// ****************************************
// Timer/counter core testbench
// ****************************************
module tb;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic cyc, stb, we, ack, cap_irq, ovf_irq, bottom;
  logic [7:0] adr;
  logic [7:0] b;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  logic [3:0] pre_tick = 4'h0;
  logic ext_pin = 1'b0;
  logic cap_pin = 1'b0;
  logic cmp_out = 1'b0;
  logic cap_ack = 1'b0;
  logic ovf_ack = 1'b0;
  logic [15:0] v;
  int n_errors = 0;
  int samples_checked = 0;

  // 50 MHz system clock
  always #10 clk_in = ~clk_in;

  tcc_core dut_u (.clk_in(clk_in), .reset_n_in(reset_n_in), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
    .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .prescale_tick_in(pre_tick), .external_tick_pin_in(ext_pin),
    .capture_pin_in(cap_pin), .comparator_output_in(cmp_out),
    .capture_irq_ack_in(cap_ack), .overflow_irq_ack_in(ovf_ack),
    .capture_irq_out(cap_irq), .overflow_irq_out(ovf_irq), .bottom_out(bottom));

  tcc_cpu_model cpu_u (.clk_in(clk_in), .ack_in(ack), .dat_in(rdat), .cyc_out(cyc),
    .stb_out(stb), .we_out(we), .adr_out(adr), .sel_out(sel), .dat_out(wdat));

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict

  // One-cycle prescaler tap pulse
  task automatic tick_pulse(input int t);
    @(posedge clk_in);
    pre_tick <= 4'h1 << t;
    @(posedge clk_in);
    pre_tick <= 4'h0;
  endtask : tick_pulse

  task automatic t_count_access();
    chk("bottom at reset", {15'h0, bottom}, 16'h0001);
    cpu_u.wr16(`TCC_ADR_CNT_HI, `TCC_ADR_CNT_LO, 16'hab01);
    cpu_u.wr(`TCC_ADR_CNT_LO, 8'h02);
    cpu_u.rd16(`TCC_ADR_CNT_LO, `TCC_ADR_CNT_HI, v);
    chk("count reuse high", v, 16'hab02);
    chk("bottom nonzero", {15'h0, bottom}, 16'h0000);
    cpu_u.rd(8'h30, b);
    chk("unmapped read", {8'h00, b}, 16'h0000);
  endtask : t_count_access

  task automatic t_tick_sources();
    cpu_u.wr16(`TCC_ADR_CNT_HI, `TCC_ADR_CNT_LO, 16'h0000);
    cpu_u.wr(`TCC_ADR_CTRL_B, 8'(tcc_pkg::src_none));
    tick_pulse(0);
    cpu_u.rd16(`TCC_ADR_CNT_LO, `TCC_ADR_CNT_HI, v);
    chk("stopped count", v, 16'h0000);
    for (int s = 2; s <= 5; s++) begin
      cpu_u.wr(`TCC_ADR_CTRL_B, 8'(s));
      tick_pulse(s - 2);
    end
    cpu_u.rd16(`TCC_ADR_CNT_LO, `TCC_ADR_CNT_HI, v);
    chk("prescaled count", v, 16'h0004);
    cpu_u.wr(`TCC_ADR_CTRL_B, 8'(tcc_pkg::src_pre_a));
    // Tick lands on the very edge that takes the write
    fork
      cpu_u.wr(`TCC_ADR_CNT_LO, 8'h40);
      tick_pulse(0);
    join
    cpu_u.wr(`TCC_ADR_CTRL_B, 8'(tcc_pkg::src_ext_rise));
    ext_pin <= 1'b1;
    repeat (6) @(posedge clk_in);
    cpu_u.wr(`TCC_ADR_CTRL_B, 8'(tcc_pkg::src_ext_fall));
    ext_pin <= 1'b0;
    repeat (6) @(posedge clk_in);
    cpu_u.wr(`TCC_ADR_CTRL_B, 8'(tcc_pkg::src_none));
    cpu_u.rd16(`TCC_ADR_CNT_LO, `TCC_ADR_CNT_HI, v);
    chk("write wins, ext ticks", v, 16'h0042);
  endtask : t_tick_sources

  task automatic t_overflow();
    cpu_u.wr(`TCC_ADR_IRQ_EN, 8'h01);
    cpu_u.wr16(`TCC_ADR_CNT_HI, `TCC_ADR_CNT_LO, 16'hffff);
    cpu_u.wr(`TCC_ADR_CTRL_B, 8'(tcc_pkg::src_pre_a));
    tick_pulse(0);
    repeat (2) @(posedge clk_in);
    chk("overflow request", {15'h0, ovf_irq}, 16'h0001);
    chk("bottom at wrap", {15'h0, bottom}, 16'h0001);
    cpu_u.rd(`TCC_ADR_FLAGS, b);
    chk("overflow flag", {8'h00, b}, 16'h0001);
    cpu_u.wr(`TCC_ADR_CTRL_B, 8'(tcc_pkg::src_none));
    @(posedge clk_in);
    ovf_ack <= 1'b1;
    @(posedge clk_in);
    ovf_ack <= 1'b0;
    repeat (2) @(posedge clk_in);
    chk("overflow serviced", {15'h0, ovf_irq}, 16'h0000);
  endtask : t_overflow

  // Pin edges timestamp a stopped counter
  task automatic t_capture();
    cpu_u.wr16(`TCC_ADR_CNT_HI, `TCC_ADR_CNT_LO, 16'h5a3c);
    cpu_u.wr(`TCC_ADR_CTRL_B, 8'h40);
    cpu_u.wr(`TCC_ADR_IRQ_EN, 8'h02);
    cpu_u.wr(`TCC_ADR_FLAGS, 8'h03);
    cap_pin <= 1'b1;
    repeat (8) @(posedge clk_in);
    chk("capture request", {15'h0, cap_irq}, 16'h0001);
    cpu_u.rd(`TCC_ADR_FLAGS, b);
    chk("capture flag", {8'h00, b}, 16'h0002);
    cpu_u.rd16(`TCC_ADR_CAP_LO, `TCC_ADR_CAP_HI, v);
    chk("capture value", v, 16'h5a3c);
    cpu_u.wr(`TCC_ADR_FLAGS, 8'h02);
    repeat (2) @(posedge clk_in);
    chk("flag write one", {15'h0, cap_irq}, 16'h0000);
    cpu_u.wr16(`TCC_ADR_CNT_HI, `TCC_ADR_CNT_LO, 16'h1111);
    cap_pin <= 1'b0;
    repeat (8) @(posedge clk_in);
    chk("wrong edge ignored", {15'h0, cap_irq}, 16'h0000);
    cap_pin <= 1'b1;
    repeat (8) @(posedge clk_in);
    cap_ack <= 1'b1;
    @(posedge clk_in);
    cap_ack <= 1'b0;
    repeat (2) @(posedge clk_in);
    chk("flag serviced", {15'h0, cap_irq}, 16'h0000);
    cpu_u.rd16(`TCC_ADR_CAP_LO, `TCC_ADR_CAP_HI, v);
    chk("capture overwrite", v, 16'h1111);
  endtask : t_capture

  task automatic t_comparator();
    cpu_u.wr(`TCC_ADR_CMP_CS, 8'h04);
    cpu_u.wr(`TCC_ADR_FLAGS, 8'h02);
    cpu_u.wr16(`TCC_ADR_CNT_HI, `TCC_ADR_CNT_LO, 16'h0777);
    cap_pin <= 1'b0;
    repeat (6) @(posedge clk_in);
    cap_pin <= 1'b1;
    repeat (8) @(posedge clk_in);
    chk("pin not routed", {15'h0, cap_irq}, 16'h0000);
    cmp_out <= 1'b1;
    repeat (8) @(posedge clk_in);
    cpu_u.rd16(`TCC_ADR_CAP_LO, `TCC_ADR_CAP_HI, v);
    chk("comparator capture", v, 16'h0777);
    cpu_u.wr(`TCC_ADR_CMP_CS, 8'h00);
    cpu_u.wr(`TCC_ADR_FLAGS, 8'h02);
  endtask : t_comparator

  // Edges from a rising pin until the request shows, then re-arm
  task automatic lat_rise(output int n);
    @(posedge clk_in);
    cap_pin <= 1'b1;
    for (n = 0; n < 20 && cap_irq !== 1'b1; n++) @(posedge clk_in);
    chk("capture latency bound", 16'(n < 20), 16'h0001);
    cpu_u.wr(`TCC_ADR_FLAGS, 8'h02);
    cap_pin <= 1'b0;
    repeat (12) @(posedge clk_in);
  endtask : lat_rise

  task automatic t_filter();
    int lu, lf;
    cpu_u.wr(`TCC_ADR_CTRL_B, 8'h40);
    cap_pin <= 1'b0;
    repeat (6) @(posedge clk_in);
    cpu_u.wr(`TCC_ADR_FLAGS, 8'h02);
    lat_rise(lu);
    cpu_u.wr(`TCC_ADR_CTRL_B, 8'hc0);
    lat_rise(lf);
    chk("filter delay", 16'(lf - lu), 16'h0004);
    cap_pin <= 1'b1;
    repeat (3) @(posedge clk_in);
    cap_pin <= 1'b0;
    repeat (12) @(posedge clk_in);
    chk("short pulse filtered", {15'h0, cap_irq}, 16'h0000);
  endtask : t_filter

  // Capture value as TOP: writable, and the input path is shut
  task automatic t_top_mode();
    logic [3:0] m;
    m = tcc_pkg::wgm_ctc_icr;
    cpu_u.wr16(`TCC_ADR_CAP_HI, `TCC_ADR_CAP_LO, 16'h55aa);
    cpu_u.rd16(`TCC_ADR_CAP_LO, `TCC_ADR_CAP_HI, v);
    chk("capture write refused", v, 16'h0777);
    cpu_u.wr(`TCC_ADR_CTRL_A, {6'h00, m[1:0]});
    cpu_u.wr(`TCC_ADR_CTRL_B, {3'h0, m[3:2], 3'h0});
    cpu_u.wr16(`TCC_ADR_CAP_HI, `TCC_ADR_CAP_LO, 16'h55aa);
    cap_pin <= 1'b1;
    repeat (8) @(posedge clk_in);
    cap_pin <= 1'b0;
    repeat (8) @(posedge clk_in);
    cpu_u.rd(`TCC_ADR_FLAGS, b);
    chk("path shut at top", {8'h00, b}, 16'h0000);
    cpu_u.rd16(`TCC_ADR_CAP_LO, `TCC_ADR_CAP_HI, v);
    chk("top value written", v, 16'h55aa);
  endtask : t_top_mode

  // Dual slope turns at TOP, fast mode wraps there
  task automatic t_modes();
    cpu_u.wr(`TCC_ADR_CTRL_A, 8'h01);
    cpu_u.wr(`TCC_ADR_CTRL_B, 8'h02);
    cpu_u.wr16(`TCC_ADR_CNT_HI, `TCC_ADR_CNT_LO, `TCC_TOP_8B);
    tick_pulse(0);
    cpu_u.rd16(`TCC_ADR_CNT_LO, `TCC_ADR_CNT_HI, v);
    chk("dual slope turn", v, 16'h00fe);
    cpu_u.wr(`TCC_ADR_CTRL_B, 8'h0a);
    cpu_u.wr16(`TCC_ADR_CNT_HI, `TCC_ADR_CNT_LO, `TCC_TOP_8B);
    cpu_u.wr(`TCC_ADR_FLAGS, 8'h03);
    tick_pulse(0);
    cpu_u.rd16(`TCC_ADR_CNT_LO, `TCC_ADR_CNT_HI, v);
    chk("fast wrap", v, 16'h0000);
    cpu_u.rd(`TCC_ADR_FLAGS, b);
    chk("fast overflow", {8'h00, b}, 16'h0001);
  endtask : t_modes

  // Main sequence
  initial begin
    repeat (4) @(posedge clk_in);
    reset_n_in <= 1'b1;
    @(posedge clk_in);
    t_count_access();
    t_tick_sources();
    t_overflow();
    t_capture();
    t_comparator();
    t_filter();
    t_top_mode();
    t_modes();
    print_verdict();
  end
endmodule : tb
`default_nettype wire
